//--- hdl/fieldbus_channel_command_diag.sv
// Channel command interpreter with diagnostic register and summary flags
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`default_nettype none
module fieldbus_channel_command_diag #(
  parameter int unsigned ID_W = 8
) (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hsel,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic                      req_valid,
  output logic [1:0]                req_svc,
  output logic [ID_W-1:0]           req_invoke_id,
  output logic [15:0]               req_remote_index,
  output logic [13:0]               req_local_index,
  output logic [7:0]                req_sub_index,
  input  wire chan_pkg::confirm_t   confirm,
  input  wire chan_pkg::indication_t indication,
  input  wire logic                 dpram_bad_code,
  input  wire logic                 txbuf_bad_code,
  output logic                      tx_error_flag,
  output logic                      rx_error_flag,
  output logic                      not_executed_flag,
  output logic                      transfer_busy_flag,
  output logic                      channel_closed_flag,
  output logic                      error_flag
);
  import chan_pkg::*;

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  // Address phase is captured; zero-wait OKAY answer in the data phase.
  logic        ph_wr_q, ph_wr_d;
  logic [7:0]  ph_addr_q, ph_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        take;

  assign take = hsel && hready && htrans[1];

  always_comb begin
    ph_wr_d   = take && hwrite;
    ph_addr_d = take ? haddr[7:0] : ph_addr_q;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ph_wr_q   <= 1'b0;
      ph_addr_q <= 8'h00;
    end else begin
      ph_wr_q   <= ph_wr_d;
      ph_addr_q <= ph_addr_d;
    end
  end

  // ==========================================================================
  // Configuration
  // ==========================================================================
  // CONFIG: [0] assigned, [1] local object defined, [9:2] local object size (bytes),
  // [17:10] local object resources.  OBJINFO is kept for future table growth.
  logic        assigned_q, assigned_d, obj_def_q, obj_def_d;
  logic [7:0]  obj_size_q, obj_size_d, obj_res_q, obj_res_d;
  logic        wr_cfg, wr_cmd, wr_diag, wr_event;

  assign wr_cfg   = ph_wr_q && (ph_addr_q == OFF_CONFIG);
  assign wr_cmd   = ph_wr_q && (ph_addr_q == OFF_CMD);
  assign wr_diag  = ph_wr_q && (ph_addr_q == OFF_DIAG);
  assign wr_event = ph_wr_q && (ph_addr_q == OFF_EVENT);

  always_comb begin
    assigned_d = wr_cfg ? hwdata[0] : assigned_q;
    obj_def_d  = wr_cfg ? hwdata[1] : obj_def_q;
    obj_size_d = wr_cfg ? hwdata[9:2] : obj_size_q;
    obj_res_d  = wr_cfg ? hwdata[17:10] : obj_res_q;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      assigned_q <= 1'b0;
      obj_def_q  <= 1'b0;
      obj_size_q <= 8'h00;
      obj_res_q  <= 8'h00;
    end else begin
      assigned_q <= assigned_d;
      obj_def_q  <= obj_def_d;
      obj_size_q <= obj_size_d;
      obj_res_q  <= obj_res_d;
    end
  end

  // ==========================================================================
  // Command decode
  // ==========================================================================
  // CMD word: [1:0] kind, [2] state operand, [10:3] station (ignored),
  // [18:11] sub-index, [31:19] local index (13 bits).  Remote index in hwdata
  // would not fit, so a write to EVENT supplies [15:0] remote index.
  logic [15:0] remote_q, remote_d;
  cmd_kind_t   kind;
  logic        open_state;
  logic [13:0] loc_idx;
  logic [8:0]  sub_idx;

  assign kind       = cmd_kind_t'(hwdata[1:0]);
  assign open_state = hwdata[2];
  assign sub_idx    = {1'b0, hwdata[18:11]};        // station field [10:3] unused
  assign loc_idx    = {1'b0, hwdata[31:19]};

  function automatic logic local_bad(input logic def, input logic [13:0] idx);
    local_bad = !def || (idx < LOCAL_MIN) || (idx > LOCAL_MAX);
  endfunction

  typedef enum logic [1:0] {S_IDLE, S_WAIT} state_t;
  state_t      st_q, st_d;
  logic        open_q, open_d;
  logic [1:0]  tries_q, tries_d;
  logic [1:0]  svc_q, svc_d;
  logic [ID_W-1:0] id_q, id_d;
  logic [13:0] lidx_q, lidx_d;
  logic [7:0]  sidx_q, sidx_d;
  logic        not_executed_flag_q, not_executed_flag_d, err_q, err_d, reqv_q, reqv_d;
  logic [31:0] diag_q, diag_d, set_v;
  logic        cmd_ok;

  always_comb begin
    st_d     = st_q;
    open_d   = open_q;
    tries_d  = tries_q;
    svc_d    = svc_q;
    id_d     = id_q;
    lidx_d   = lidx_q;
    sidx_d   = sidx_q;
    not_executed_flag_d   = not_executed_flag_q;
    err_d    = err_q;
    reqv_d   = 1'b0;
    remote_d = wr_event ? hwdata[15:0] : remote_q;
    set_v    = 32'h0000_0000;
    cmd_ok   = 1'b0;
    if (wr_cmd && kind != CMD_NONE) begin
      not_executed_flag_d = 1'b0;
      if (!assigned_q) begin
        err_d = 1'b1;
      end else if (st_q != S_IDLE) begin
        set_v[BIT_PROG] = 1'b1;
      end else if (kind == CMD_OPEN_CLOSE) begin
        cmd_ok = 1'b1;
        svc_d  = open_state ? SVC_INIT : SVC_ABORT;
      end else if (!open_q) begin
        set_v[BIT_PROG] = 1'b1;
      end else if (local_bad(obj_def_q, loc_idx)) begin
        set_v[BIT_RANGE_TX] = 1'b1;
      end else if ((remote_q > REMOTE_MAX) || (sub_idx > SUB_MAX) || (sub_idx[7:0] > obj_res_q)) begin
        set_v[BIT_RANGE_TX] = 1'b1;
      end else begin
        cmd_ok = 1'b1;
        svc_d  = (kind == CMD_READ) ? SVC_READ : SVC_WRITE;
      end
      if (cmd_ok) begin
        st_d    = S_WAIT;
        reqv_d  = 1'b1;
        tries_d = 2'd1;
        id_d    = id_q + 1'b1;
        lidx_d  = loc_idx;
        sidx_d  = sub_idx[7:0];
      end
    end
    // Abort is unconfirmed: sending the request ends the command
    if (st_q == S_WAIT && svc_q == SVC_ABORT) begin
      st_d   = S_IDLE;
      open_d = 1'b0;
    end
    if (st_q == S_WAIT && confirm.valid) begin
      if (confirm.svc != svc_q) begin
        set_v[BIT_RESP] = 1'b1;
      end else if (svc_q != SVC_INIT && svc_q != SVC_ABORT && confirm.invoke_id != id_q) begin
        set_v[BIT_RESP] = 1'b1;
      end
      if (confirm.nak && svc_q != SVC_ABORT) begin
        set_v[BIT_NAK] = 1'b1;
      end
      if (svc_q == SVC_READ && !confirm.nak && confirm.byte_count != obj_size_q) begin
        set_v[BIT_RANGE_TX] = 1'b1;
      end
      if (confirm.nak && (svc_q == SVC_READ || svc_q == SVC_WRITE) && tries_q != TRIES) begin
        tries_d = tries_q + 2'd1;
        reqv_d  = 1'b1;
      end else begin
        st_d = S_IDLE;
        if (confirm.nak && (svc_q == SVC_READ || svc_q == SVC_WRITE)) begin
          not_executed_flag_d = 1'b1;
        end
        if (svc_q == SVC_INIT) begin
          open_d = !confirm.nak;
        end else if (svc_q == SVC_ABORT) begin
          open_d = 1'b0;
        end
      end
    end
    if (dpram_bad_code) begin
      set_v[BIT_FMT_RX] = 1'b1;
    end
    if (txbuf_bad_code) begin
      set_v[BIT_FMT_TX] = 1'b1;
    end
    if (indication.valid && (indication.obj_bad || indication.sub_over ||
        (indication.kind == SVC_WRITE && indication.count_bad))) begin
      set_v[BIT_RANGE_RX] = 1'b1;
    end
    // Write-one-to-clear; a new event in the same cycle wins over the clear
    diag_d = (diag_q & ~(wr_diag ? hwdata : 32'h0000_0000)) | set_v;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q     <= S_IDLE;
      open_q   <= 1'b0;
      tries_q  <= 2'd0;
      svc_q    <= SVC_INIT;
      id_q     <= '0;
      lidx_q   <= 14'h0000;
      sidx_q   <= 8'h00;
      not_executed_flag_q   <= 1'b0;
      err_q    <= 1'b0;
      reqv_q   <= 1'b0;
      remote_q <= 16'h0000;
      diag_q   <= DIAG_RESET;
    end else begin
      st_q     <= st_d;
      open_q   <= open_d;
      tries_q  <= tries_d;
      svc_q    <= svc_d;
      id_q     <= id_d;
      lidx_q   <= lidx_d;
      sidx_q   <= sidx_d;
      not_executed_flag_q   <= not_executed_flag_d;
      err_q    <= err_d;
      reqv_q   <= reqv_d;
      remote_q <= remote_d;
      diag_q   <= diag_d;
    end
  end

  // ==========================================================================
  // Summary flags and outputs
  // ==========================================================================
  logic tx_error_flag_q, rx_error_flag_q, busy_q, closed_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_error_flag_q   <= 1'b0;
      rx_error_flag_q   <= 1'b0;
      busy_q   <= 1'b0;
      closed_q <= 1'b1;
    end else begin
      tx_error_flag_q   <= |diag_d[31:16];
      rx_error_flag_q   <= |diag_d[15:0];
      busy_q   <= (st_d == S_WAIT);
      closed_q <= !open_d;
    end
  end

  // Read word is latched at the address phase so hrdata is a flop; it uses next-state
  // values so a write in the data phase just before is already seen
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      OFF_STATUS: rd_mux = {26'h0, !open_d, st_d == S_WAIT, |diag_d[31:16], |diag_d[15:0], not_executed_flag_d, err_d};
      OFF_DIAG:   rd_mux = diag_d;
      OFF_CONFIG: rd_mux = {14'h0, obj_res_d, obj_size_d, obj_def_d, assigned_d};
      OFF_EVENT:  rd_mux = {16'h0, remote_d};
      default:    rd_mux = 32'h0000_0000;
    endcase
    hrdata_d = (take && !hwrite) ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) hrdata_q <= 32'h0000_0000;
    else         hrdata_q <= hrdata_d;
  end

  assign hrdata              = hrdata_q;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign req_valid           = reqv_q;
  assign req_svc             = svc_q;
  assign req_invoke_id       = id_q;
  assign req_remote_index    = remote_q;
  assign req_local_index     = lidx_q;
  assign req_sub_index       = sidx_q;
  assign tx_error_flag       = tx_error_flag_q;
  assign rx_error_flag       = rx_error_flag_q;
  assign not_executed_flag   = not_executed_flag_q;
  assign transfer_busy_flag  = busy_q;
  assign channel_closed_flag = closed_q;
  assign error_flag          = err_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence nak_rw_s;
    st_q == S_WAIT && confirm.valid && confirm.nak && (svc_q == SVC_READ || svc_q == SVC_WRITE);
  endsequence
  tx_error_flag_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 tx_error_flag == |$past(diag_d[31:16])) else $error("tx flag wrong");
  rx_error_flag_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 rx_error_flag == |$past(diag_d[15:0])) else $error("rx flag wrong");
  not_executed_flag_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nak_rw_s and tries_q == TRIES |=> not_executed_flag) else $error("not_executed_flag not set");
  fmt_rx_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dpram_bad_code |=> diag_q[BIT_FMT_RX]) else $error("bit 9 not set");
  fmt_tx_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    txbuf_bad_code |=> diag_q[BIT_FMT_TX]) else $error("bit 25 not set");
  nak_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nak_rw_s |=> diag_q[BIT_NAK]) else $error("bit 20 not set");
  unassigned_err_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cmd && kind != CMD_NONE && !assigned_q |=> error_flag) else $error("error flag missing");
  busy_prog_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_cmd && kind != CMD_NONE && assigned_q && busy_q |=> diag_q[BIT_PROG]) else $error("bit 31 missing");
  busy_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid |-> transfer_busy_flag) else $error("busy low during request");
  sequence conf_s;
    st_q == S_WAIT && confirm.valid;
  endsequence
  logic rw_go;
  assign rw_go = wr_cmd && assigned_q && st_q == S_IDLE && (kind == CMD_READ || kind == CMD_WRITE);
  closed_prog_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rw_go && !open_q |=> diag_q[BIT_PROG]) else $error("bit 31 missing on closed channel");
  local_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rw_go && open_q && local_bad(obj_def_q, loc_idx) |=> diag_q[BIT_RANGE_TX] && !req_valid)
    else $error("bit 28 missing");
  remote_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rw_go && open_q && remote_q > REMOTE_MAX |=> diag_q[BIT_RANGE_TX]) else $error("bit 28 missing on remote index");
  rx_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    indication.valid && indication.obj_bad |=> diag_q[BIT_RANGE_RX]) else $error("bit 12 not set");
  resp_svc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conf_s and confirm.svc != svc_q |=> diag_q[BIT_RESP]) else $error("bit 30 not set");
  init_nak_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conf_s and confirm.nak && svc_q == SVC_INIT |=> diag_q[BIT_NAK] && channel_closed_flag) else $error("init nak");
  nak_retry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nak_rw_s and tries_q != TRIES |=> req_valid && transfer_busy_flag) else $error("no retry after nak");
  busy_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conf_s and !confirm.nak |=> !transfer_busy_flag) else $error("busy after confirmation");
  abort_close_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == S_WAIT && svc_q == SVC_ABORT |=> channel_closed_flag && !transfer_busy_flag) else $error("close stuck");
endmodule
`default_nettype wire

//--- hdl/chan_pkg.sv
// Package: register map, diagnostic bit positions, command codes and limits for the channel unit
`default_nettype none
package chan_pkg;
  localparam logic [7:0]  OFF_CMD      = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_DIAG     = 8'h08;
  localparam logic [7:0]  OFF_CONFIG   = 8'h0C;
  localparam logic [7:0]  OFF_EVENT    = 8'h10;
  localparam logic [7:0]  OFF_OBJINFO  = 8'h14;
  localparam int          BIT_FMT_RX   = 9;
  localparam int          BIT_RANGE_RX = 12;
  localparam int          BIT_NAK      = 20;
  localparam int          BIT_FMT_TX   = 25;
  localparam int          BIT_RANGE_TX = 28;
  localparam int          BIT_RESP     = 30;
  localparam int          BIT_PROG     = 31;
  localparam logic [13:0] LOCAL_MIN    = 14'd100;
  localparam logic [13:0] LOCAL_MAX    = 14'd499;
  localparam logic [15:0] REMOTE_MAX   = 16'd16383;
  localparam logic [8:0]  SUB_MAX      = 9'd255;
  localparam logic [1:0]  TRIES        = 2'd3;
  localparam logic [31:0] DIAG_RESET   = 32'h0000_0000;
  localparam logic [1:0]  SVC_INIT     = 2'h0;
  localparam logic [1:0]  SVC_READ     = 2'h1;
  localparam logic [1:0]  SVC_WRITE    = 2'h2;
  localparam logic [1:0]  SVC_ABORT    = 2'h3;
  typedef enum logic [1:0] {CMD_NONE, CMD_OPEN_CLOSE, CMD_READ, CMD_WRITE} cmd_kind_t;
  typedef struct packed {
    logic       valid;
    logic       nak;
    logic [1:0] svc;
    logic [7:0] invoke_id;
    logic [7:0] byte_count;
  } confirm_t;
  typedef struct packed {
    logic       valid;
    logic [1:0] kind;
    logic       obj_bad;
    logic       sub_over;
    logic       count_bad;
  } indication_t;
endpackage
`default_nettype wire

//--- tb/remote_station_model.sv
// Remote station model: answers request telegrams with confirmation pulses
`default_nettype none
module remote_station_model (
  input  wire logic          sys_clk,
  input  wire logic          req_valid,
  input  wire logic [1:0]    req_svc,
  input  wire logic [7:0]    req_invoke_id,
  input  wire logic          nak_all,
  input  wire logic [1:0]    fault_mode,
  input  wire logic [7:0]    delay,
  input  wire logic [7:0]    byte_count,
  output var chan_pkg::confirm_t confirm
);
  timeunit 1ns;
  timeprecision 1ns;
  import chan_pkg::*;
  confirm_t c;
  initial confirm = 20'h00000;
  // ==========================================================================
  // Reply engine
  // Abort is an unconfirmed service, so it never gets a reply
  always begin
    @(posedge sys_clk);
    if (req_valid === 1'b1 && req_svc !== SVC_ABORT) begin
      c.valid      = 1'b1;
      c.nak        = nak_all;
      c.svc        = (fault_mode == 2'h1) ? req_svc ^ 2'h3 : req_svc;
      c.invoke_id  = (fault_mode == 2'h2) ? req_invoke_id ^ 8'h01 : req_invoke_id;
      c.byte_count = byte_count;
      repeat (delay) @(posedge sys_clk);
      confirm <= c;
      @(posedge sys_clk);
      // Released fields show the inverse so stale values cannot pass
      confirm <= {1'b0, ~c[18:0]};
    end
  end
endmodule
`default_nettype wire

//--- tb/fieldbus_channel_command_diag_tb.sv
// Self-checking bench for the channel command and diagnostic unit
`default_nettype none
module fieldbus_channel_command_diag_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import chan_pkg::*;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, hreadyout, hresp, req_valid;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hrdata_s;
  logic [1:0]  htrans = 2'h0, req_svc, fault_mode = 2'h0;
  logic [7:0]  req_invoke_id, req_sub_index, delay = 8'h01, byte_count = 8'h04;
  logic [15:0] req_remote_index;
  logic [13:0] req_local_index;
  logic        dpram_bad_code = 1'b0, txbuf_bad_code = 1'b0, nak_all = 1'b0;
  logic        tx_error_flag, rx_error_flag, not_executed_flag, transfer_busy_flag, channel_closed_flag, error_flag;
  confirm_t    confirm;
  indication_t indication = 6'h00;
  int          errors = 0, tests_run = 0, n_req = 0, n0;
  logic [12:0] r_loc [4] = '{13'h0063, 13'h01F4, 13'h0064, 13'h0064};
  logic [15:0] r_rem [4] = '{16'h0016, 16'h0016, 16'h4000, 16'h0016};
  logic [7:0]  r_sub [4] = '{8'h00, 8'h00, 8'h00, 8'h0B};
  logic [1:0]  i_kind [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
  logic [2:0]  i_flag [5] = '{3'h4, 3'h4, 3'h4, 3'h2, 3'h1};

  always #10 sys_clk = ~sys_clk;
  // Pre-edge capture keeps read data free of races with the register updates
  always @(posedge sys_clk) hrdata_s <= hrdata;
  always @(posedge sys_clk) if (req_valid === 1'b1) n_req <= n_req + 1;

  fieldbus_channel_command_diag u_fieldbus_channel_command_diag (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .req_valid(req_valid), .req_svc(req_svc), .req_invoke_id(req_invoke_id), .req_remote_index(req_remote_index),
    .req_local_index(req_local_index), .req_sub_index(req_sub_index), .confirm(confirm), .indication(indication),
    .dpram_bad_code(dpram_bad_code), .txbuf_bad_code(txbuf_bad_code), .tx_error_flag(tx_error_flag),
    .rx_error_flag(rx_error_flag), .not_executed_flag(not_executed_flag), .transfer_busy_flag(transfer_busy_flag),
    .channel_closed_flag(channel_closed_flag), .error_flag(error_flag));

  remote_station_model u_remote_station_model (
    .sys_clk(sys_clk), .req_valid(req_valid), .req_svc(req_svc), .req_invoke_id(req_invoke_id),
    .nak_all(nak_all), .fault_mode(fault_mode), .delay(delay), .byte_count(byte_count), .confirm(confirm));

  // ==========================================================================
  // Bus and check tasks
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    #1 rd = hrdata_s;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ahb(a, 1'b0, 32'h0, d);
    check(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(a, 1'b1, d, x);
  endtask
  // After a command, wait two cycles, then up to n more for the busy flag to go low
  task automatic settle(input int n);
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < n && transfer_busy_flag !== 1'b0; i++) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(input logic [1:0] k, input logic st, input logic [7:0] stn, input logic [7:0] sub,
                     input logic [12:0] loc);
    wr(OFF_CMD, {loc, sub, stn, st, k});
    settle(40);
  endtask
  // Read the diagnostic word, then clear every bit with write-one-to-clear
  task automatic diag_is(input logic [31:0] exp);
    rd_chk(OFF_DIAG, exp);
    wr(OFF_DIAG, 32'hFFFFFFFF);
  endtask
  task automatic finish_test();
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    finish_test();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(OFF_DIAG, 32'h00000000);
    check({30'h0, hresp, hreadyout}, 32'h00000001);
    rd_chk(OFF_STATUS, 32'h00000020);
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h00000000);
    cmd(2'h1, 1'b1, 8'h00, 8'h00, 13'h0000);
    rd_chk(OFF_STATUS, 32'h00000021);
    wr(OFF_CONFIG, 32'h00002813);
    cmd(2'h2, 1'b0, 8'h00, 8'h00, 13'h0064);
    rd_chk(OFF_STATUS, 32'h00000029);
    diag_is(32'h1 << BIT_PROG);
    rd_chk(OFF_STATUS, 32'h00000021);
    nak_all = 1'b1;
    cmd(2'h1, 1'b1, 8'h00, 8'h00, 13'h0000);
    diag_is(32'h1 << BIT_NAK);
    rd_chk(OFF_STATUS, 32'h00000021);
    nak_all = 1'b0;
    cmd(2'h1, 1'b1, 8'hFF, 8'h00, 13'h0000);
    check({30'h0, req_svc}, {30'h0, SVC_INIT});
    rd_chk(OFF_STATUS, 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      n0 = n_req;
      wr(OFF_EVENT, {16'h0000, r_rem[i]});
      cmd(2'h2, 1'b0, 8'h00, r_sub[i], r_loc[i]);
      diag_is(32'h1 << BIT_RANGE_TX);
      check(32'(n_req - n0), 32'h0);
    end
    wr(OFF_EVENT, 32'h00000016);
    cmd(2'h2, 1'b0, 8'h00, 8'h03, 13'h0096);
    diag_is(32'h0);
    check({22'h0, req_svc, req_sub_index}, {22'h0, SVC_READ, 8'h03});
    check({2'h0, req_local_index, req_remote_index}, {2'h0, 14'h0096, 16'h0016});
    byte_count = 8'h03;
    cmd(2'h2, 1'b0, 8'h00, 8'h00, 13'h0064);
    diag_is(32'h1 << BIT_RANGE_TX);
    byte_count = 8'h04;
    for (int m = 1; m < 3; m++) begin
      fault_mode = 2'(m);
      cmd(2'h3, 1'b0, 8'h00, 8'h00, 13'h0064);
      diag_is(32'h1 << BIT_RESP);
    end
    fault_mode = 2'h0;
    nak_all = 1'b1;
    n0 = n_req;
    cmd(2'h2, 1'b0, 8'h00, 8'h00, 13'h0064);
    check(32'(n_req - n0), 32'h3);
    rd_chk(OFF_STATUS, 32'h0000000B);
    check({26'h0, channel_closed_flag, transfer_busy_flag, tx_error_flag, rx_error_flag, not_executed_flag,
           error_flag}, 32'h0000000B);
    diag_is(32'h1 << BIT_NAK);
    nak_all = 1'b0;
    cmd(2'h2, 1'b0, 8'h00, 8'h00, 13'h0064);
    rd_chk(OFF_STATUS, 32'h00000001);
    delay = 8'h0A;
    wr(OFF_CMD, {13'h0064, 8'h00, 8'h00, 1'b0, 2'h2});
    repeat (2) @(posedge sys_clk);
    #1 check({31'h0, transfer_busy_flag}, 32'h1);
    cmd(2'h2, 1'b0, 8'h00, 8'h00, 13'h0064);
    diag_is(32'h1 << BIT_PROG);
    delay = 8'h01;
    @(posedge sys_clk);
    dpram_bad_code <= 1'b1;
    @(posedge sys_clk);
    dpram_bad_code <= 1'b0;
    settle(0);
    rd_chk(OFF_STATUS, 32'h00000005);
    diag_is(32'h1 << BIT_FMT_RX);
    rd_chk(OFF_STATUS, 32'h00000001);
    @(posedge sys_clk);
    txbuf_bad_code <= 1'b1;
    @(posedge sys_clk);
    txbuf_bad_code <= 1'b0;
    settle(0);
    diag_is(32'h1 << BIT_FMT_TX);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      indication <= {1'b1, i_kind[i], i_flag[i]};
      @(posedge sys_clk);
      indication <= {1'b0, ~i_kind[i], ~i_flag[i]};
      settle(0);
      diag_is(32'h1 << BIT_RANGE_RX);
    end
    // A size mismatch only counts for a write indication
    @(posedge sys_clk);
    indication <= {1'b1, 2'h1, 3'h1};
    @(posedge sys_clk);
    indication <= 6'h00;
    settle(0);
    diag_is(32'h0);
    // The link is closed once it is no longer needed
    cmd(2'h1, 1'b0, 8'h00, 8'h00, 13'h0000);
    rd_chk(OFF_STATUS, 32'h00000021);
    finish_test();
  end
endmodule
`default_nettype wire
